// File: tb/vectored_interrupt_controller_tb.sv
// self-checking bench for the vectored interrupt controller
`default_nettype none
module vectored_interrupt_controller_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int NI = 12;
  localparam int NS = NI + vic_pkg::INT_BASE;
  localparam logic [11:0] STA = vic_pkg::ADDR_STATUS;
  localparam logic [11:0] ENA = vic_pkg::ADDR_ENABLE;
  localparam logic [11:0] CLR = vic_pkg::ADDR_CLEAR;
  localparam logic [11:0] CFG = vic_pkg::ADDR_CFG_BASE;
  logic clk_sys, rst_n, hsel, hwrite, hready, hreadyout, hresp, slow, fast_pin;
  logic fast_irq_to_core, std_irq_to_core, cur_valid, a;
  logic [31:0] haddr, hwdata, hrdata, r;
  logic [1:0] htrans, s;
  logic [2:0] hsize, ext_pin;
  logic [3:0] want, m;
  logic [7:0] cur_src;
  logic [NI-1:0] periph_irq;
  int n_errors, compares, seed, w, w2, src;
  int lv[NS];
  assign hready = hreadyout;
  vic_core #(.NUM_INT(NI)) vic_core_i (.clk_sys, .rst_n, .periph_irq,
    .ext_fast_irq_in(fast_pin), .ext_irq_in(ext_pin), .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hwdata, .hready, .hreadyout, .hresp, .hrdata, .fast_irq_to_core,
    .std_irq_to_core, .cur_src, .cur_valid);
  vic_pins_model vic_pins_model_i (.clk_sys, .slow, .want, .fast_pin, .ext_pin);
  // free-running system clock
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  task automatic close_out();
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  // bounded wait for the slave to be ready
  task automatic wait_rdy();
    int k;
    k = 0;
    do begin
      @(posedge clk_sys);
      k++;
    end while (hreadyout !== 1'b1 && k < 20);
    if (hreadyout !== 1'b1) begin
      n_errors++;
      close_out();
    end
  endtask
  // one single word transfer: address phase, then data phase
  task automatic bus(input logic wr_en, input logic [11:0] ad, input logic [31:0] d);
    @(posedge clk_sys);
    haddr <= {20'h0, ad};
    hwrite <= wr_en;
    hsel <= 1'b1;
    htrans <= 2'h2;
    wait_rdy();
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    wait_rdy();
    r = hrdata;
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask
  task automatic rchk(input string n, input logic [11:0] ad, input logic [31:0] e);
    bus(1'b0, ad, 32'h0);
    chk(n, e, r);
  endtask
  task automatic settle();
    repeat (8) @(posedge clk_sys);
  endtask
  // drive source i: pins through the model, peripherals directly
  task automatic drive(input int i, input logic v);
    @(posedge clk_sys);
    if (i < vic_pkg::INT_BASE) want[i] <= v;
    else periph_irq[i - vic_pkg::INT_BASE] <= v;
  endtask
  // expected winner: highest level, lowest index on ties, -1 if none
  function automatic int winner(input logic [NS-1:0] p);
    int b;
    b = -1;
    for (int i = 1; i < NS; i++) begin
      if (p[i] && (b < 0 || lv[i] > lv[b])) b = i;
    end
    return b;
  endfunction
  initial begin
    seed = 8205;
    n_errors = 0;
    compares = 0;
    {rst_n, hsel, hwrite, slow} = 4'h0;
    {haddr, hwdata, htrans, want, periph_irq} = '0;
    hsize = vic_pkg::HSIZE_WORD;
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'b1;
    rchk("status", STA, 32'h0);
    rchk("enable", ENA, 32'h0);
    rchk("unmapped", 12'h0FC, 32'h0);
    $display("test reset done");
    bus(1'b1, ENA, 32'hFFFF);
    // all four pending at level 5 first, then random levels over random pending sets
    for (int t = 0; t < 4; t++) begin
      for (int i = 4; i < 8; i++) begin
        lv[i] = t == 0 ? 5 : $random(seed) & 7;
        bus(1'b1, CFG + 12'(4 * i), 32'(lv[i]));
      end
      m = t == 0 ? 4'hF : 4'($random(seed)) | 4'h1;
      drive(8, 1'b0);
      periph_irq[3:0] <= m;
      repeat (4) @(posedge clk_sys);
      w = winner({8'h0, m, 4'h0});
      chk("cur_src", w, 32'(cur_src));
      chk("cur_valid", 32'h1, {31'h0, cur_valid});
      chk("std", 32'h1, {31'h0, std_irq_to_core});
      chk("fast", 32'h0, {31'h0, fast_irq_to_core});
      rchk("current", vic_pkg::ADDR_CURRENT, (32'(lv[w]) << 12) | 32'h100 | 32'(w));
      bus(1'b1, ENA, 32'hFFFF ^ (32'h1 << w));
      repeat (3) @(posedge clk_sys);
      w2 = winner({8'h0, m, 4'h0} & ~(16'h1 << w));
      chk("std masked", 32'(w2 >= 0), {31'h0, std_irq_to_core});
      chk("valid masked", 32'(w2 >= 0), {31'h0, cur_valid});
      if (w2 >= 0) chk("cur masked", w2, 32'(cur_src));
      periph_irq <= '0;
      bus(1'b1, CLR, 32'hFFFF);
      bus(1'b1, ENA, 32'hFFFF);
      repeat (3) @(posedge clk_sys);
      chk("std idle", 32'h0, {31'h0, std_irq_to_core});
      chk("valid idle", 32'h0, {31'h0, cur_valid});
    end
    $display("test priority done");
    // every pin sensitivity, then internal level and edge
    for (int t = 0; t < 6; t++) begin
      src = t < 4 ? 1 : 4;
      s = 2'(t % 4);
      a = (s == vic_pkg::SENS_HIGH || s == vic_pkg::SENS_RISE);
      slow <= t[0];
      drive(src, !a);
      bus(1'b1, CFG + 12'(4 * src), {26'h0, s, 4'h0});
      settle();
      bus(1'b1, CLR, 32'hFFFF);
      settle();
      rchk("idle pend", STA, 32'h0);
      drive(src, a);
      settle();
      chk("std trig", 32'h1, {31'h0, std_irq_to_core});
      chk("cur trig", src, 32'(cur_src));
      bus(1'b1, CLR, 32'hFFFF);
      settle();
      rchk("after clear", STA, s[0] ? 32'h0 : 32'h1 << src);
      drive(src, !a);
      settle();
      bus(1'b1, CLR, 32'hFFFF);
    end
    $display("test sensitivity done");
    drive(0, 1'b1);
    settle();
    chk("fast on", 32'h1, {31'h0, fast_irq_to_core});
    chk("std quiet", 32'h0, {31'h0, std_irq_to_core});
    bus(1'b1, ENA, 32'hFFFE);
    repeat (3) @(posedge clk_sys);
    chk("fast masked", 32'h0, {31'h0, fast_irq_to_core});
    $display("test fast done");
    close_out();
  end
endmodule // vectored_interrupt_controller_tb
`default_nettype wire

// File: tb/vic_pins_model.sv
// far-side model driving the request pins from a wanted pattern
`default_nettype none
module vic_pins_model (
  input wire logic clk_sys, // system clock
  input wire logic slow, // one extra cycle of lag
  input wire logic [3:0] want, // wanted levels, bit0 fast
  output logic fast_pin, // fast request pin
  output logic [2:0] ext_pin // standard request pins
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] lag;
  // pins start low before the first edge
  initial begin
    lag = 4'h0;
    {ext_pin, fast_pin} = 4'h0;
  end
  // pins follow the pattern promptly or one edge late
  always @(posedge clk_sys) begin
    lag <= want;
    {ext_pin, fast_pin} <= slow ? lag : want;
  end
endmodule // vic_pins_model
`default_nettype wire

// File: verilog/vic_core.sv
// vectored interrupt controller with ahb-lite register access
//
// Added by the designer: the register offsets and the AHB-Lite register port.
`default_nettype none
module vic_core #(
  parameter int NUM_INT = 12 // peripheral request lines
) (
  input wire logic clk_sys, // system clock
  input wire logic rst_n, // synchronous reset
  input wire logic [NUM_INT-1:0] periph_irq, // peripheral requests, same clock
  input wire logic ext_fast_irq_in, // fast request pin
  input wire logic [vic_pkg::NUM_EXT-1:0] ext_irq_in, // standard request pins
  input wire logic hsel, // slave select
  input wire logic [31:0] haddr, // address
  input wire logic [1:0] htrans, // transfer type
  input wire logic hwrite, // write flag
  input wire logic [2:0] hsize, // transfer size
  input wire logic [31:0] hwdata, // write data
  input wire logic hready, // bus ready
  output logic hreadyout, // slave ready
  output logic hresp, // always okay
  output logic [31:0] hrdata, // read data
  output logic fast_irq_to_core, // fast request to core
  output logic std_irq_to_core, // standard request to core
  output logic [vic_pkg::IDX_W-1:0] cur_src, // current source index
  output logic cur_valid // current source valid
);
  localparam int NSRC = vic_pkg::INT_BASE + NUM_INT;
  localparam int PW = vic_pkg::PRIO_W;

  logic [vic_pkg::NUM_EXT:0] pin_meta;
  logic [vic_pkg::NUM_EXT:0] pin_sync;
  logic [NSRC-1:0] raw;
  logic [NSRC-1:0] prev;
  logic [NSRC-1:0] trig;
  logic [NSRC-1:0] pend;
  logic [NSRC-1:0] en;
  logic [NSRC-1:0] clr;
  logic [NSRC-1:0] req;
  logic [NSRC-1:0] std_mask;
  logic [PW-1:0] cfg_prio [NSRC];
  logic [1:0] cfg_sens [NSRC];
  logic [NSRC*PW-1:0] prio_flat;
  logic [vic_pkg::IDX_W-1:0] win_idx;
  logic [PW-1:0] win_prio;
  logic win_valid;
  logic [PW-1:0] cur_level;
  logic acc;
  logic wr_pend;
  logic [11:0] wr_addr;
  logic [9:0] wr_off;
  logic [9:0] rd_off;
  logic wr_cfg;
  logic [31:0] next_rdata;

  // two-stage synchroniser for the request pins
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pin_meta <= '0;
      pin_sync <= '0;
    end else begin
      pin_meta <= {ext_irq_in, ext_fast_irq_in};
      pin_sync <= pin_meta;
    end
  end

  // source vector and previous sample for edge detection
  assign raw = {periph_irq, pin_sync};
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      prev <= '0;
    end else begin
      prev <= raw;
    end
  end

  // ahb-lite address phase capture; writes land in the data phase
  assign acc = hsel && htrans[vic_pkg::HTRANS_ACTIVE_BIT] && hready;
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      wr_pend <= 1'b0;
      wr_addr <= '0;
    end else begin
      wr_pend <= acc && hwrite && (hsize == vic_pkg::HSIZE_WORD);
      wr_addr <= haddr[11:0];
    end
  end

  // config window decode for both phases
  assign wr_off = wr_addr[11:2] - vic_pkg::ADDR_CFG_BASE[11:2];
  assign rd_off = haddr[11:2] - vic_pkg::ADDR_CFG_BASE[11:2];
  assign wr_cfg = wr_pend && (wr_addr >= vic_pkg::ADDR_CFG_BASE) && (wr_off < 10'(NSRC));

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      en <= '0;
    end else if (wr_pend && wr_addr == vic_pkg::ADDR_ENABLE) begin
      en <= hwdata[NSRC-1:0];
    end
  end

  // clear strobe, one cycle in the write data phase
  assign clr = (wr_pend && wr_addr == vic_pkg::ADDR_CLEAR) ? hwdata[NSRC-1:0] : '0;

  // per-source config, trigger detection
  for (genvar i = 0; i < NSRC; i++) begin : g_src
    // internal: only high level or rising edge kept
    always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
        cfg_prio[i] <= vic_pkg::CFG_PRIO_RESET;
        cfg_sens[i] <= vic_pkg::SENS_HIGH;
      end else if (wr_cfg && wr_off == 10'(i)) begin
        cfg_prio[i] <= hwdata[vic_pkg::CFG_PRIO_LSB +: PW];
        if (i >= vic_pkg::INT_BASE) begin
          cfg_sens[i] <= {1'b0, hwdata[vic_pkg::CFG_SENS_LSB]};
        end else begin
          cfg_sens[i] <= hwdata[vic_pkg::CFG_SENS_LSB +: 2];
        end
      end
    end
    assign trig[i] = (cfg_sens[i] == vic_pkg::SENS_HIGH) ? raw[i] :
                     (cfg_sens[i] == vic_pkg::SENS_LOW) ? !raw[i] :
                     (cfg_sens[i] == vic_pkg::SENS_RISE) ? (raw[i] && !prev[i]) :
                     (!raw[i] && prev[i]);
    assign prio_flat[i*PW +: PW] = cfg_prio[i];
    assign std_mask[i] = (i != vic_pkg::FAST_BIT);
  end

  // sticky pending; a trigger in the clear cycle wins
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pend <= '0;
    end else begin
      pend <= (pend & ~clr) | trig;
    end
  end

  // eight-level encoder over standard sources only
  assign req = pend & en & std_mask;
  vic_prio_encoder #(.N(NSRC), .IDX_W(vic_pkg::IDX_W), .PRIO_W(PW)) u_enc (
    .req(req),
    .prio_flat(prio_flat),
    .win_idx(win_idx),
    .win_prio(win_prio),
    .win_valid(win_valid)
  );

  // fast output from the fast pin source alone
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      fast_irq_to_core <= 1'b0;
    end else begin
      fast_irq_to_core <= pend[vic_pkg::FAST_BIT] && en[vic_pkg::FAST_BIT];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      std_irq_to_core <= 1'b0;
      cur_src <= '0;
      cur_valid <= 1'b0;
      cur_level <= '0;
    end else begin
      std_irq_to_core <= |req;
      cur_src <= win_idx;
      cur_valid <= win_valid;
      cur_level <= win_prio;
    end
  end

  // read mux; unmapped addresses read zero
  always_comb begin
    next_rdata = '0;
    case (haddr[11:0])
      vic_pkg::ADDR_STATUS: next_rdata = 32'(pend);
      vic_pkg::ADDR_ENABLE: next_rdata = 32'(en);
      vic_pkg::ADDR_CURRENT: begin
        next_rdata[vic_pkg::IDX_W-1:0] = cur_src;
        next_rdata[vic_pkg::CUR_VALID_BIT] = cur_valid;
        next_rdata[vic_pkg::CUR_LEVEL_LSB +: PW] = cur_level;
      end
      default: begin
        for (int i = 0; i < NSRC; i++) begin
          if (haddr[11:0] >= vic_pkg::ADDR_CFG_BASE && rd_off == 10'(i)) begin
            next_rdata[vic_pkg::CFG_PRIO_LSB +: PW] = cfg_prio[i];
            next_rdata[vic_pkg::CFG_SENS_LSB +: 2] = cfg_sens[i];
          end
        end
      end
    endcase
  end

  // read data registered for the data phase; zero wait, always okay
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      hrdata <= '0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hrdata <= (acc && !hwrite) ? next_rdata : '0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // helper: highest level among standard requests
  logic [PW-1:0] max_prio;
  always_comb begin
    max_prio = '0;
    for (int i = 0; i < NSRC; i++) begin
      if (req[i] && cfg_prio[i] > max_prio) begin
        max_prio = cfg_prio[i];
      end
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  fast_only_a: assert property (!(pend[0] && en[0]) |=> !fast_irq_to_core)
    else $error("fast request without fast source");
  fast_follow_a: assert property ($rose(pin_sync[0])
    && cfg_sens[0] == vic_pkg::SENS_HIGH && en[0] |=> ##1 fast_irq_to_core)
    else $error("fast pin not forwarded");
  std_raise_a: assert property (|req |=> std_irq_to_core)
    else $error("standard request missing");
  level_order_a: assert property (|req |=> cur_level == $past(max_prio))
    else $error("winner not highest level");
  int_edge_a: assert property (cfg_sens[vic_pkg::INT_BASE] == vic_pkg::SENS_RISE
    && periph_irq[0] && !prev[vic_pkg::INT_BASE] |=> pend[vic_pkg::INT_BASE])
    else $error("internal edge not latched");
  pin_fall_a: assert property (cfg_sens[1] == vic_pkg::SENS_FALL
    && !pin_sync[1] && prev[1] |=> pend[1])
    else $error("falling edge not latched");
  pin_low_a: assert property (cfg_sens[2] == vic_pkg::SENS_LOW && !pin_sync[2] |=> pend[2])
    else $error("low level not latched");
  mask_gate_a: assert property (!(|req) |=> !std_irq_to_core && !cur_valid)
    else $error("masked source reached core");
  // the vector must name a source that was requesting one cycle before
  vector_valid_a: assert property (cur_valid |-> |($past(req) & (NSRC'(1) << cur_src)))
    else $error("vector names idle source");
  hold_std_a: assert property ((|req) [*2] |=> std_irq_to_core && $past(std_irq_to_core))
    else $error("standard request dropped");

  fast_seen_c: cover property ($rose(fast_irq_to_core));
  std_seen_c: cover property ($rose(std_irq_to_core) ##[1:20] !std_irq_to_core);
  two_pend_c: cover property ($countones(req) > 1 && cur_level != 3'h0);
endmodule // vic_core
`default_nettype wire

// File: verilog/vic_pkg.sv
// constants for the vectored interrupt controller
`default_nettype none
package vic_pkg;
  // source layout: fast pin, three request pins, then peripherals
  localparam int PRIO_W = 3;
  localparam int IDX_W = 8;
  localparam int NUM_EXT = 3;
  localparam int FAST_BIT = 0;
  localparam int EXT_BASE = 1;
  localparam int INT_BASE = 4;
  // register byte addresses (low 12 address bits decoded)
  localparam logic [11:0] ADDR_STATUS = 12'h000;
  localparam logic [11:0] ADDR_ENABLE = 12'h004;
  localparam logic [11:0] ADDR_CLEAR = 12'h008;
  localparam logic [11:0] ADDR_CURRENT = 12'h00C;
  localparam logic [11:0] ADDR_CFG_BASE = 12'h040;
  // per-source config word fields
  localparam int CFG_PRIO_LSB = 0;
  localparam int CFG_SENS_LSB = 4;
  localparam logic [PRIO_W-1:0] CFG_PRIO_RESET = 3'h0;
  // current-source word fields
  localparam int CUR_VALID_BIT = 8;
  localparam int CUR_LEVEL_LSB = 12;
  // trigger sensitivity codes
  localparam logic [1:0] SENS_HIGH = 2'h0;
  localparam logic [1:0] SENS_RISE = 2'h1;
  localparam logic [1:0] SENS_LOW = 2'h2;
  localparam logic [1:0] SENS_FALL = 2'h3;
  // ahb-lite encodings
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam int HTRANS_ACTIVE_BIT = 1;
endpackage
`default_nettype wire

// File: verilog/vic_prio_encoder.sv
// priority encoder picking the highest-level request, lowest index on ties
`default_nettype none
module vic_prio_encoder #(
  parameter int N = 16,
  parameter int IDX_W = 8,
  parameter int PRIO_W = 3
) (
  input wire logic [N-1:0] req, // pending enabled requests
  input wire logic [N*PRIO_W-1:0] prio_flat, // level of each request
  output logic [IDX_W-1:0] win_idx, // index of the winner
  output logic [PRIO_W-1:0] win_prio, // level of the winner
  output logic win_valid // some request present
);
  // strict compare keeps the lower index on equal levels
  always_comb begin
    win_idx = '0;
    win_prio = '0;
    win_valid = 1'b0;
    for (int i = 0; i < N; i++) begin
      if (req[i] && (!win_valid || prio_flat[i*PRIO_W +: PRIO_W] > win_prio)) begin
        win_valid = 1'b1;
        win_prio = prio_flat[i*PRIO_W +: PRIO_W];
        win_idx = IDX_W'(i);
      end
    end
  end
endmodule // vic_prio_encoder
`default_nettype wire
